// ==== gpb_ctrl.sv ====
`timescale 1ns/1ps
module gpb_ctrl
    import gpb_pkg::*;
(
    input  wire logic       clk_i,                       // oscillator clock
    input  wire logic       rst_n_i,                     // async reset, low
    input  wire logic       cs_n_i,                      // chip select, low
    input  wire logic       rd_n_i,                      // read strobe, low
    input  wire logic       wr_n_i,                      // write strobe, low
    input  wire logic       register_select_i,           // high: status/command
    input  wire logic [7:0] data_i,                      // host data in
    output logic      [7:0] data_o,                      // host data out
    output logic            data_oe_o,                   // host data drive
    input  wire logic       ifc_received_latched_in_i,   // latched ifc seen
    output logic            latch_clear_out_o,           // clears ifc latch
    input  wire logic       attention_monitor_in_i,      // bus attention level
    output logic            attention_drive_out_o,       // bus attention drive
    input  wire logic       system_ctrl_switch_in_i,     // system controller switch
    input  wire logic       srq_i,                       // service request line
    input  wire logic       dav_i,                       // data valid line
    input  wire logic       ifc_i,                       // interface clear level
    output logic            ifc_o,                       // interface clear value
    output logic            ifc_oe_o,                    // interface clear drive
    output logic            ren_o,                       // remote enable
    input  wire logic       count_i,                     // event count input
    output logic            sync_o,                      // instruction clock
    output logic            spi_o,                       // special interrupt
    output logic            cic_o                        // controller in charge
);
    // ***************************************************************
    // synchronisers and divider
    // ***************************************************************
    logic [SI_W-1:0] raw;
    logic [SI_W-1:0] sy;
    logic            instr_stb;

    assign raw = {dav_i, count_i, ifc_i, srq_i, system_ctrl_switch_in_i,
                  attention_monitor_in_i, ifc_received_latched_in_i};

    gpb_sync #(.W(SI_W)) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .async_i (raw),
        .sync_o  (sy)
    );

    gpb_div u_div (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .sync_o  (sync_o),
        .stb_o   (instr_stb)
    );

    // ***************************************************************
    // host port
    // ***************************************************************
    logic       wr_prev_q, wr_prev_d;
    logic       rd_act_q, rd_act_d;
    logic       rsel_q, rsel_d;
    logic [7:0] ibuf_q, ibuf_d;
    logic       ibf_q, ibf_d;
    logic [7:0] obuf_q, obuf_d;
    logic       obf_q, obf_d;
    logic [7:0] dout_q, dout_d;
    logic       oe_q, oe_d;
    logic       wr_take, cmd_stb;
    logic [7:0] cmd;
    logic [7:0] status;
    logic       load_take, cnt_copy;
    logic [7:0] ev_cnt_q;

    // host strobes qualified by chip select
    assign wr_take = ~cs_n_i & ~wr_n_i & ~wr_prev_q;
    assign cmd_stb = wr_take & register_select_i;
    assign cmd     = data_i;

    always_comb begin
        wr_prev_d = ~cs_n_i & ~wr_n_i;
        rd_act_d  = ~cs_n_i & ~rd_n_i;
        rsel_d    = rd_act_d ? register_select_i : rsel_q;
        ibuf_d    = ibuf_q;
        ibf_d     = ibf_q;
        obuf_d    = obuf_q;
        obf_d     = obf_q;
        // data byte into input buffer
        if (wr_take && !register_select_i) begin
            ibuf_d = data_i;
            ibf_d  = 1'b1;
        end else if (load_take) begin
            ibf_d  = 1'b0;
        end
        // output buffer emptied by a data read, refill wins
        if (rd_act_q && !rd_act_d && !rsel_q) begin
            obf_d = 1'b0;
        end
        if (cnt_copy) begin
            obuf_d = ev_cnt_q;
            obf_d  = 1'b1;
        end
        dout_d = register_select_i ? status : obuf_q;
        oe_d   = rd_act_d;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_prev_q <= 1'b0;
            rd_act_q  <= 1'b0;
            rsel_q    <= 1'b0;
            ibuf_q    <= BYTE_RST;
            ibf_q     <= 1'b0;
            obuf_q    <= BYTE_RST;
            obf_q     <= 1'b0;
            dout_q    <= BYTE_RST;
            oe_q      <= 1'b0;
        end else begin
            wr_prev_q <= wr_prev_d;
            rd_act_q  <= rd_act_d;
            rsel_q    <= rsel_d;
            ibuf_q    <= ibuf_d;
            ibf_q     <= ibf_d;
            obuf_q    <= obuf_d;
            obf_q     <= obf_d;
            dout_q    <= dout_d;
            oe_q      <= oe_d;
        end
    end

    assign data_o    = dout_q;
    assign data_oe_o = oe_q;
    assign load_take = cmd_stb && (cmd == CMD_EVC_LOAD);
    assign cnt_copy  = cmd_stb && (cmd == CMD_RD_CNT);

    // ***************************************************************
    // control state machine
    // ***************************************************************
    gpb_state_e       st_q, st_d;
    logic [TMR_W-1:0] tmr_q, tmr_d;
    logic             atn_q, atn_d;
    logic             ifc_q, ifc_d;
    logic             ren_q, ren_d;
    logic             clr_q, clr_d;
    logic             ifc_lost, seize_err, in_charge;

    assign in_charge = (st_q != S_IDLE) && (st_q != S_IFC_SEND);
    // clear received only counts when someone else is system controller
    assign ifc_lost  = sy[SI_IFC_RECEIVED_LATCHED_IN] & ~sy[SI_SYC];

    always_comb begin
        st_d      = st_q;
        tmr_d     = tmr_q;
        atn_d     = atn_q;
        ifc_d     = 1'b0;
        ren_d     = ren_q & sy[SI_SYC];
        clr_d     = 1'b0;
        seize_err = 1'b0;
        if (cmd_stb && cmd == CMD_REN_ON && sy[SI_SYC]) begin
            ren_d = 1'b1;
        end
        if (cmd_stb && cmd == CMD_REN_OFF) begin
            ren_d = 1'b0;
        end
        if (ifc_lost) begin
            st_d  = S_IDLE;
            atn_d = 1'b0;
            clr_d = 1'b1;
        end else begin
            case (st_q)
                S_IDLE, S_ACTIVE, S_STANDBY: begin
                    if (cmd_stb && cmd == CMD_IFC) begin
                        if (sy[SI_SYC]) begin
                            st_d  = S_IFC_SEND;
                            ifc_d = 1'b1;                // full hold from the first cycle
                            tmr_d = TMR_W'(IFC_HOLD_CYC - 1);
                        end else begin
                            seize_err = 1'b1;
                        end
                    end else if (cmd_stb && cmd == CMD_TCS && st_q == S_STANDBY) begin
                        st_d = S_TCS_WAIT;
                    end else if (cmd_stb && cmd == CMD_TCA && st_q == S_STANDBY) begin
                        atn_d = 1'b1;
                        st_d  = S_ATN_WAIT;
                        tmr_d = TMR_W'(ATN_WAIT_CYC - 1);
                    end else if (cmd_stb && cmd == CMD_GTS && st_q == S_ACTIVE) begin
                        atn_d = 1'b0;
                        st_d  = S_STANDBY;
                    end
                end
                S_TCS_WAIT: begin
                    // seize only between bytes, never mid handshake
                    if (!sy[SI_DAV]) begin
                        atn_d = 1'b1;
                        st_d  = S_ATN_WAIT;
                        tmr_d = TMR_W'(ATN_WAIT_CYC - 1);
                    end
                end
                S_ATN_WAIT: begin
                    if (sy[SI_ATN]) begin
                        st_d = S_ACTIVE;
                    end else if (tmr_q == '0) begin
                        atn_d     = 1'b0;
                        st_d      = S_STANDBY;
                        seize_err = 1'b1;
                    end else begin
                        tmr_d = tmr_q - 1'b1;
                    end
                end
                S_IFC_SEND: begin
                    ifc_d = 1'b1;
                    if (tmr_q == '0) begin
                        ifc_d     = 1'b0;
                        atn_d     = 1'b1;
                        st_d      = S_ACTIVE;
                        seize_err = ~sy[SI_IFC];
                    end else begin
                        tmr_d = tmr_q - 1'b1;
                    end
                end
                default: begin
                    st_d  = S_IDLE;
                    atn_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q  <= S_IDLE;
            tmr_q <= '0;
            atn_q <= 1'b0;
            ifc_q <= 1'b0;
            ren_q <= 1'b0;
            clr_q <= LATCH_CLEAR_RST;
        end else begin
            st_q  <= st_d;
            tmr_q <= tmr_d;
            atn_q <= atn_d;
            ifc_q <= ifc_d;
            ren_q <= ren_d;
            clr_q <= clr_d;
        end
    end

    // ***************************************************************
    // event counter
    // ***************************************************************
    logic [1:0] smp_q, smp_d;
    logic       cnt_prev_q, cnt_prev_d;
    logic       evc_en_q, evc_en_d;
    logic [7:0] ev_cnt_d;
    logic [7:0] tgt_q, tgt_d;
    logic       ev_hit;

    always_comb begin
        smp_d      = smp_q;
        cnt_prev_d = cnt_prev_q;
        evc_en_d   = evc_en_q;
        ev_cnt_d   = ev_cnt_q;
        tgt_d      = tgt_q;
        ev_hit     = 1'b0;
        if (cmd_stb && cmd == CMD_EVC_ON)  evc_en_d = 1'b1;
        if (cmd_stb && cmd == CMD_EVC_OFF) evc_en_d = 1'b0;
        if (instr_stb) begin
            smp_d = (smp_q == 2'(SAMPLE_INSTR - 1)) ? 2'h0 : 2'(smp_q + 2'h1);
        end
        if (instr_stb && smp_q == 2'h0) begin
            cnt_prev_d = sy[SI_CNT];
            if (evc_en_q && cnt_prev_q && !sy[SI_CNT]) begin
                ev_cnt_d = ev_cnt_q + 8'h01;
                ev_hit   = (ev_cnt_d == tgt_q);
            end
        end
        if (load_take) begin
            tgt_d    = ibuf_q;
            ev_cnt_d = 8'h00;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            smp_q      <= 2'h0;
            cnt_prev_q <= 1'b0;
            evc_en_q   <= 1'b0;
            ev_cnt_q   <= BYTE_RST;
            tgt_q      <= BYTE_RST;
        end else begin
            smp_q      <= smp_d;
            cnt_prev_q <= cnt_prev_d;
            evc_en_q   <= evc_en_d;
            ev_cnt_q   <= ev_cnt_d;
            tgt_q      <= tgt_d;
        end
    end

    // ***************************************************************
    // sticky event flags, set wins over acknowledge
    // ***************************************************************
    logic [4:0] flg_q, flg_d;        // syc, err, srq, ev, iface_clear_received_flag
    logic       syc_prev_q, syc_prev_d;
    logic [1:0] warm_q, warm_d;      // synchroniser settle count
    logic [4:0] flg_set;
    logic       spi_q, spi_d;
    logic       cic_q, cic_d;

    always_comb begin
        syc_prev_d = sy[SI_SYC];
        // no switch change reported while the synchroniser fills after reset
        warm_d     = (&warm_q) ? warm_q : 2'(warm_q + 2'h1);
        flg_set    = {(sy[SI_SYC] ^ syc_prev_q) & (&warm_q),
                      seize_err,
                      sy[SI_SRQ] & in_charge,
                      ev_hit,
                      ifc_lost & in_charge};
        flg_d      = (cmd_stb && cmd == CMD_IACK) ? 5'h00 : flg_q;
        flg_d      = flg_d | flg_set;
        spi_d      = |flg_d;
        cic_d      = (st_d != S_IDLE) && (st_d != S_IFC_SEND);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flg_q      <= 5'h00;
            syc_prev_q <= 1'b0;
            warm_q     <= 2'h0;
            spi_q      <= 1'b0;
            cic_q      <= 1'b0;
        end else begin
            flg_q      <= flg_d;
            syc_prev_q <= syc_prev_d;
            warm_q     <= warm_d;
            spi_q      <= spi_d;
            cic_q      <= cic_d;
        end
    end

    // status byte layout
    always_comb begin
        status          = 8'h00;
        status[ST_OBF]  = obf_q;
        status[ST_IBF]  = ibf_q;
        status[ST_IFACE_CLEAR_RECEIVED_FLAG] = flg_q[0];
        status[ST_EV]   = flg_q[1];
        status[ST_SRQ]  = flg_q[2];
        status[ST_ERR]  = flg_q[3];
        status[ST_SYC]  = flg_q[4];
    end

    // ***************************************************************
    // bus outputs
    // ***************************************************************
    assign latch_clear_out_o     = clr_q;
    assign attention_drive_out_o = atn_q;
    assign ifc_o                 = ifc_q;
    assign ifc_oe_o              = ifc_q;
    assign ren_o                 = ren_q;
    assign spi_o                 = spi_q;
    assign cic_o                 = cic_q;
endmodule

// ==== gpb_pkg.sv ====
package gpb_pkg;

    // ***************************************************************
    // clock and timing
    // ***************************************************************
    localparam int CLK_HZ        = 25_000_000;
    localparam int CLK_MHZ       = CLK_HZ / 1_000_000;
    localparam int XTAL_DIV      = 15;                    // oscillator to instruction cycle
    localparam int SAMPLE_INSTR  = 3;                     // instruction cycles per count sample
    localparam int IFC_HOLD_US   = 100;                   // least time ifc is driven
    localparam int IFC_HOLD_CYC  = IFC_HOLD_US * CLK_MHZ; // least time, whole cycles
    localparam int ATN_WAIT_US   = 10;                    // longest wait for attention echo
    localparam int ATN_WAIT_CYC  = ATN_WAIT_US * CLK_MHZ; // longest time, whole cycles
    localparam int TMR_W         = 12;

    // ***************************************************************
    // host commands, written with register select high
    // ***************************************************************
    localparam logic [7:0] CMD_IACK     = 8'hE0; // clear event flags
    localparam logic [7:0] CMD_TCS      = 8'hE1; // take control synchronously
    localparam logic [7:0] CMD_TCA      = 8'hE2; // take control asynchronously
    localparam logic [7:0] CMD_GTS      = 8'hE3; // go to standby, release attention
    localparam logic [7:0] CMD_IFC      = 8'hE4; // send interface clear
    localparam logic [7:0] CMD_REN_ON   = 8'hE5;
    localparam logic [7:0] CMD_REN_OFF  = 8'hE6;
    localparam logic [7:0] CMD_EVC_ON   = 8'hE7; // enable event counting
    localparam logic [7:0] CMD_EVC_OFF  = 8'hE8;
    localparam logic [7:0] CMD_EVC_LOAD = 8'hE9; // load target from data byte, zero counter
    localparam logic [7:0] CMD_RD_CNT   = 8'hEA; // copy counter to output buffer

    // ***************************************************************
    // interrupt status byte fields
    // ***************************************************************
    localparam int ST_OBF  = 0;
    localparam int ST_IBF  = 1;
    localparam int ST_IFACE_CLEAR_RECEIVED_FLAG = 2;
    localparam int ST_EV   = 4;
    localparam int ST_SRQ  = 5;
    localparam int ST_ERR  = 6;
    localparam int ST_SYC  = 7;

    // ***************************************************************
    // synchronised input lanes
    // ***************************************************************
    localparam int SI_IFC_RECEIVED_LATCHED_IN = 0;
    localparam int SI_ATN  = 1;
    localparam int SI_SYC  = 2;
    localparam int SI_SRQ  = 3;
    localparam int SI_IFC  = 4;
    localparam int SI_CNT  = 5;
    localparam int SI_DAV  = 6;
    localparam int SI_W    = 7;

    // ***************************************************************
    // reset values
    // ***************************************************************
    localparam logic LATCH_CLEAR_RST = 1'b1;
    localparam logic [7:0] BYTE_RST  = 8'h00;

    typedef enum logic [5:0] {
        S_IDLE     = 6'h01, // not in charge
        S_ACTIVE   = 6'h02, // in charge, attention driven
        S_STANDBY  = 6'h04, // in charge, attention released
        S_TCS_WAIT = 6'h08, // waiting for handshake to go quiet
        S_ATN_WAIT = 6'h10, // waiting for attention echo
        S_IFC_SEND = 6'h20  // driving interface clear
    } gpb_state_e;

endpackage

// ==== gpb_sync.sv ====
`timescale 1ns/1ps
module gpb_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,   // system clock
    input  wire logic         rst_n_i, // async reset, low
    input  wire logic [W-1:0] async_i, // raw inputs
    output logic      [W-1:0] sync_o   // synchronised inputs
);
    // ***************************************************************
    // two flip-flop synchroniser per lane
    // ***************************************************************
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_lane
            logic meta_q;
            logic stab_q;
            // first stage feeds only the second
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    meta_q <= 1'b0;
                    stab_q <= 1'b0;
                end else begin
                    meta_q <= async_i[g];
                    stab_q <= meta_q;
                end
            end
            assign sync_o[g] = stab_q;
        end
    endgenerate
endmodule

// ==== gpb_div.sv ====
`timescale 1ns/1ps
module gpb_div
    import gpb_pkg::*;
(
    input  wire logic clk_i,   // oscillator clock
    input  wire logic rst_n_i, // async reset, low
    output logic      sync_o,  // instruction clock out
    output logic      stb_o    // one pulse per instruction cycle
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic       sync_q;
    logic       sync_d;
    logic       stb_q;
    logic       stb_d;

    // ***************************************************************
    // divide by fifteen, high for the first eight cycles
    // ***************************************************************
    always_comb begin
        stb_d  = (cnt_q == 4'(XTAL_DIV - 1));
        cnt_d  = stb_d ? 4'h0 : 4'(cnt_q + 4'h1);
        sync_d = (cnt_d < 4'((XTAL_DIV + 1) / 2));
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q  <= 4'h0;
            sync_q <= 1'b0;
            stb_q  <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            sync_q <= sync_d;
            stb_q  <= stb_d;
        end
    end

    assign sync_o = sync_q;
    assign stb_o  = stb_q;
endmodule

// ==== gpb_ctrl_props.sv ====
`timescale 1ns/1ps
module gpb_ctrl_props (
    input wire logic clk_i,                     // clock
    input wire logic rst_n_i,                   // reset, low
    input wire logic cs_n_i,                    // select
    input wire logic rd_n_i,                    // read
    input wire logic ifc_received_latched_in_i, // latched ifc
    input wire logic system_ctrl_switch_in_i,   // switch
    input wire logic srq_i,                     // service req
    input wire logic data_oe_o,                 // data drive
    input wire logic latch_clear_out_o,         // latch clear
    input wire logic attention_drive_out_o,     // atn drive
    input wire logic ifc_o,                     // ifc value
    input wire logic ifc_oe_o,                  // ifc drive
    input wire logic ren_o,                     // remote
    input wire logic sync_o,                    // instr clock
    input wire logic spi_o,                     // interrupt
    input wire logic cic_o                      // in charge
);
    // ***************************************************************
    // checks on the pins
    // ***************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_sync_hi; sync_o [*8] ##1 !sync_o; endsequence
    sequence s_lost; (ifc_received_latched_in_i && !system_ctrl_switch_in_i) [*3]; endsequence
    a_sync_shape: assert property ($fell(sync_o) |-> !sync_o [*7] ##1 s_sync_hi)
        else $error("sync period wrong");
    a_read_drive: assert property (!cs_n_i && !rd_n_i |=> data_oe_o)
        else $error("read not driven");
    a_idle_float: assert property (cs_n_i || rd_n_i |=> !data_oe_o)
        else $error("data driven when idle");
    a_ifc_true: assert property (ifc_oe_o |-> ifc_o)
        else $error("ifc driven false");
    a_ifc_hold: assert property ($rose(ifc_oe_o) |-> ifc_oe_o [*8])
        else $error("ifc pulse short");
    a_srq_spi: assert property (cic_o && srq_i |-> ##[1:5] spi_o)
        else $error("srq gave no interrupt");
    a_ifc_lost: assert property (s_lost |-> ##[0:2] (latch_clear_out_o && !cic_o))
        else $error("latched ifc ignored");
    a_ren_drop: assert property (!system_ctrl_switch_in_i [*4] |=> !ren_o)
        else $error("remote kept without switch");
    a_atn_charge: assert property ($rose(attention_drive_out_o) |-> ##[0:1] cic_o)
        else $error("atn without charge");
endmodule
bind gpb_ctrl gpb_ctrl_props u_props (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i),
    .rd_n_i(rd_n_i), .ifc_received_latched_in_i(ifc_received_latched_in_i),
    .system_ctrl_switch_in_i(system_ctrl_switch_in_i), .srq_i(srq_i), .data_oe_o(data_oe_o),
    .latch_clear_out_o(latch_clear_out_o), .attention_drive_out_o(attention_drive_out_o),
    .ifc_o(ifc_o), .ifc_oe_o(ifc_oe_o), .ren_o(ren_o), .sync_o(sync_o), .spi_o(spi_o),
    .cic_o(cic_o));

// ==== gpb_bus_model.sv ====
`timescale 1ns/1ps
module gpb_bus_model (
    input  wire logic clk_i,    // clock
    input  wire logic atn_i,    // attention drive
    input  wire logic ifc_v_i,  // ifc value
    input  wire logic ifc_oe_i, // ifc drive
    input  wire logic lclr_i,   // latch clear
    input  wire logic echo_i,   // atn path works
    input  wire logic busy_i,   // bytes moving
    input  wire logic rem_i,    // remote ifc
    output logic      atn_o,    // bus attention
    output logic      ifc_o,    // ifc wire
    output logic      ifc_received_latched_in_o,   // latched ifc
    output logic      dav_o,    // data valid
    output logic      cnt_o     // ndac, counted
);
    // ***************************************************************
    // instrument bus
    // ***************************************************************
    logic [6:0] ph_q = 7'h00;
    initial atn_o = 1'b0;
    initial ifc_received_latched_in_o = 1'b0;
    // ifc wire, false when nobody drives
    assign ifc_o = ifc_oe_i ? ifc_v_i : 1'b0;
    // one byte handshake per 100 clocks, ndac falls once each
    assign dav_o = busy_i && ph_q < 7'h32;
    assign cnt_o = !(busy_i && ph_q >= 7'h32);
    // phase, atn echo and external ifc latch
    always @(posedge clk_i) begin
        ph_q <= (busy_i && ph_q != 7'h63) ? ph_q + 7'h01 : 7'h00;
        atn_o <= echo_i & atn_i;
        ifc_received_latched_in_o <= rem_i | (ifc_received_latched_in_o & !lclr_i);
    end
endmodule

// ==== gpb_ctrl_tb.sv ====
`timescale 1ns/1ps
module gpb_ctrl_tb
    import gpb_pkg::*;
;
    logic clk_i = 1'b0, rst_n_i = 1'b0, cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, rsel = 1'b0;
    logic system_ctrl_switch_in = 1'b1, srq = 1'b0, echo = 1'b1, busy = 1'b0, rem = 1'b0, oe_d = 1'b0;
    logic [7:0] din = 8'h00, dout, dbus, n;
    logic oe, lclr, atn, atn_m, ifc_received_latched_in, ifcv, ifcoe, ifcw, dav, cnt, ren, sync, spi, cic;
    logic [7:0] exp_q[$];
    int n_mismatch = 0, num_checks = 0;
    // ***************************************************************
    // design, bus and host wiring
    // ***************************************************************
    assign dbus = oe ? dout : din;
    gpb_ctrl dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .rd_n_i(rd_n),
        .wr_n_i(wr_n), .register_select_i(rsel), .data_i(dbus), .data_o(dout), .data_oe_o(oe),
        .ifc_received_latched_in_i(ifc_received_latched_in), .latch_clear_out_o(lclr),
        .attention_monitor_in_i(atn_m), .attention_drive_out_o(atn),
        .system_ctrl_switch_in_i(system_ctrl_switch_in), .srq_i(srq), .dav_i(dav), .ifc_i(ifcw),
        .ifc_o(ifcv), .ifc_oe_o(ifcoe), .ren_o(ren), .count_i(cnt), .sync_o(sync),
        .spi_o(spi), .cic_o(cic));
    gpb_bus_model u_bus (.clk_i(clk_i), .atn_i(atn), .ifc_v_i(ifcv), .ifc_oe_i(ifcoe),
        .lclr_i(lclr), .echo_i(echo), .busy_i(busy), .rem_i(rem), .atn_o(atn_m),
        .ifc_o(ifcw), .ifc_received_latched_in_o(ifc_received_latched_in), .dav_o(dav), .cnt_o(cnt));
    initial forever #20 clk_i = ~clk_i;
    task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic cyc(int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    // host write, select first, one strobe
    task automatic wr(logic s, logic [7:0] d);
        cyc(1);
        cs_n = 1'b0;
        cyc(1);
        {wr_n, rsel, din} = {1'b0, s, d};
        cyc(2);
        {cs_n, wr_n} = 2'b11;
        cyc(1);
    endtask
    // host read, expected byte noted for the monitor
    task automatic rd(logic s, logic [7:0] e);
        cyc(1);
        cs_n = 1'b0;
        exp_q.push_back(e);
        cyc(1);
        {rd_n, rsel} = {1'b0, s};
        cyc(2);
        {cs_n, rd_n} = 2'b11;
        cyc(2);
    endtask
    // read monitor, compares first driven byte of each read
    always @(posedge clk_i) begin
        if (oe === 1'b1 && oe_d === 1'b0 && exp_q.size() > 0) begin
            check("read byte", dout, exp_q.pop_front());
        end
        oe_d <= oe;
    end
    // watchdog
    initial begin
        #(40 * 12000);
        n_mismatch++;
        finish_test();
    end
    // main sequence
    initial begin
        void'($urandom(32'hB0981630));
        n = 8'($urandom_range(4, 1));
        cyc(4);
        check("reset outs", {cic, ren, atn, ifcoe, spi, oe}, 8'h00);
        check("clear latch", lclr, 1'b1);
        rst_n_i = 1'b1;
        cyc(3);
        check("clear idle", lclr, 1'b0);
        rd(1'b1, 8'h00);
        wr(1'b1, CMD_IACK);
        wr(1'b1, CMD_REN_ON);
        check("remote on", ren, 1'b1);
        wr(1'b1, CMD_REN_OFF);
        check("remote off", ren, 1'b0);
        wr(1'b1, CMD_REN_ON);
        wr(1'b1, CMD_IFC);
        check("ifc drive", {ifcoe, ifcv}, 8'h03);
        cyc(2600);
        check("in charge", {cic, atn}, 8'h03);
        rd(1'b1, 8'h00);
        wr(1'b1, CMD_GTS);
        wr(1'b1, CMD_TCA);
        cyc(20);
        check("tca seize", {cic, atn}, 8'h03);
        wr(1'b1, CMD_GTS);
        echo = 1'b0;
        wr(1'b1, CMD_TCA);
        cyc(300);
        check("tca timeout", atn, 1'b0);
        rd(1'b1, 8'h40);
        wr(1'b1, CMD_IACK);
        {echo, busy} = 2'b11;
        cyc(5);
        wr(1'b1, CMD_TCS);
        cyc(20);
        check("tcs waits", atn, 1'b0);
        cyc(40);
        check("tcs seize", atn, 1'b1);
        {busy, srq} = 2'b01;
        cyc(6);
        check("srq irq", spi, 1'b1);
        srq = 1'b0;
        rd(1'b1, 8'h20);
        wr(1'b1, CMD_IACK);
        check("irq clear", spi, 1'b0);
        {system_ctrl_switch_in, rem} = 2'b01;
        cyc(1);
        rem = 1'b0;
        cyc(10);
        check("lost charge", {cic, ren, atn}, 8'h00);
        rd(1'b1, 8'h84);
        wr(1'b1, CMD_IACK);
        wr(1'b0, n);
        rd(1'b1, 8'h02);
        wr(1'b1, CMD_EVC_LOAD);
        wr(1'b1, CMD_EVC_ON);
        busy = 1'b1;
        cyc(n * 100);
        busy = 1'b0;
        cyc(100);
        rd(1'b1, 8'h10);
        wr(1'b1, CMD_RD_CNT);
        rd(1'b1, 8'h11);
        rd(1'b0, n);
        rd(1'b1, 8'h10);
        // counting off, interface clear refused without the switch
        wr(1'b1, CMD_EVC_OFF);
        busy = 1'b1;
        cyc(200);
        busy = 1'b0;
        wr(1'b1, CMD_IFC);
        wr(1'b1, CMD_RD_CNT);
        rd(1'b1, 8'h51);
        rd(1'b0, n);
        finish_test();
    end
endmodule
